/* File: logic/fpc_pkg.sv */
// fpc_pkg: constants and types for the flow pulse input counter
// assumes a single system clock domain
package fpc_pkg;
	localparam int CNT_W = 32;
	// 18 bits so the 1 ms default period fits
	localparam int SPER_W = 18;
	// clock period in ps, used to turn times into cycle counts
	localparam int CLK_PERIOD_PS = 4000;
	// default flow sampling period: 1 ms, much faster than ordinary channels
	localparam int FLOW_SAMPLE_US = 1000;
	localparam int FLOW_SAMPLE_CYC = (FLOW_SAMPLE_US * 1000000) / CLK_PERIOD_PS;

	// pulse mode field encodings
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_UNI = 3'h1;
	localparam logic [2:0] MODE_STATUS = 3'h2;
	localparam logic [2:0] MODE_BI_PD = 3'h3;
	localparam logic [2:0] MODE_BI_FR = 3'h4;
	localparam logic [2:0] MODE_BI_QUAD = 3'h5;

	localparam logic [31:0] CNT_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		FPC_ST_IDLE = 3'b001,
		FPC_ST_RUN = 3'b010,
		FPC_ST_CAPT = 3'b100
	} fpc_state_e;
endpackage

/* File: logic/fpc_edge_if.sv */
// fpc_edge_if: carries sampled pin levels and edge strobes between modules
// assumes one producer (sampler) and one consumer (counter core)
`timescale 1ns/1ps
interface fpc_edge_if;
	logic [1:0] lvl;
	logic [1:0] prev;
	logic [1:0] rise;
	logic tick;
	modport src (output lvl, output prev, output rise, output tick);
	modport dst (input lvl, input prev, input rise, input tick);
endinterface

/* File: logic/fpc_sampler.sv */
// fpc_sampler: synchronises the pin pair and samples it at the flow period
// assumes pins are asynchronous, closed reads as 1
`timescale 1ns/1ps
module fpc_sampler #(
	parameter int SPER_W = fpc_pkg::SPER_W
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [1:0] pin_in,
	input wire logic [SPER_W-1:0] sample_period,
	fpc_edge_if.src eo
);
	logic [1:0] sync1_ff;
	logic [1:0] sync2_ff;
	logic [1:0] samp_ff;
	logic [1:0] prev_ff;
	logic [1:0] rise_ff;
	logic tick_ff;
	logic [SPER_W-1:0] div_ff;
	wire div_done = (div_ff == '0);
	wire [SPER_W-1:0] nxt_div = div_done ? (sample_period - SPER_W'(1)) : (div_ff - SPER_W'(1));

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_ff <= 2'h0;
			sync2_ff <= 2'h0;
		end else begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			div_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			tick_ff <= div_done;
		end
	end

	// edges only compare successive period samples, so bounce inside a period is ignored
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			samp_ff <= 2'h0;
			prev_ff <= 2'h0;
			rise_ff <= 2'h0;
		end else if (div_done) begin
			prev_ff <= samp_ff;
			samp_ff <= sync2_ff;
			rise_ff <= sync2_ff & ~samp_ff;
		end
	end

	assign eo.lvl = samp_ff;
	assign eo.prev = prev_ff;
	assign eo.rise = rise_ff;
	assign eo.tick = tick_ff;

	a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!rstn)
		tick_ff && sample_period == SPER_W'(2) && $stable(sample_period) |=> !tick_ff ##1 tick_ff)
		else $error("sample tick spacing wrong");
endmodule // fpc_sampler

/* File: logic/fpc_top.sv */
// fpc_top: flow pulse input counter for one odd/even pulse input pair
// assumes configuration is static while counting; log_tick from the log timer
// Summary of operation
// - uni mode: each close edge counts one
// - counts per log period give volume
// - pins separately or jointly assignable
// - odd mode decides one or two pins
// - two-pin odd mode seizes the even pin
// - one function per pin at once
// - bi modes only from odd input
// - bi mode: both pins give direction
// - own fast configurable sampling period
// - even input offers reduced mode set
// - pulse-direction: odd pulses, even level direction
// - fwd/rev: odd forward, even reverse pulses
// - quadrature gray decode, net only
// - separate fwd/rev counters, net, or independent in pulse-direction only
`timescale 1ns/1ps
module fpc_top #(
	parameter int CNT_W = fpc_pkg::CNT_W,
	parameter int SPER_W = fpc_pkg::SPER_W,
	parameter int SPER_DEF = fpc_pkg::FLOW_SAMPLE_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [1:0] pulse_pin,
	input wire logic [2:0] odd_mode,
	input wire logic [2:0] even_mode,
	input wire logic store_indep,
	input wire logic [SPER_W-1:0] sample_period,
	input wire logic log_tick,
	output logic [CNT_W-1:0] odd_data_ff,
	output logic [CNT_W-1:0] even_data_ff,
	output logic data_valid_ff,
	output logic even_seized_ff,
	output logic cfg_err_ff,
	output logic [1:0] status_lvl_ff
);
	fpc_edge_if eif ();
	fpc_pkg::fpc_state_e state_ff;
	fpc_pkg::fpc_state_e nxt_state;
	logic [CNT_W-1:0] fwd_ff;
	logic [CNT_W-1:0] rev_ff;
	logic [CNT_W-1:0] even_uni_ff;

	// zero period would wrap the divider to 2^18 clocks per sample; fall back to default
	wire [SPER_W-1:0] sper_eff = (sample_period == '0) ? SPER_W'(SPER_DEF) : sample_period;

	fpc_sampler #(.SPER_W(SPER_W)) u_samp (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.pin_in(pulse_pin),
		.sample_period(sper_eff),
		.eo(eif)
	);

	// pin allocation
	wire odd_bi = (odd_mode == fpc_pkg::MODE_BI_PD) || (odd_mode == fpc_pkg::MODE_BI_FR)
		|| (odd_mode == fpc_pkg::MODE_BI_QUAD);
	wire seize = odd_bi;
	wire even_bad = (even_mode != fpc_pkg::MODE_OFF) && (even_mode != fpc_pkg::MODE_UNI)
		&& (even_mode != fpc_pkg::MODE_STATUS);
	wire odd_bad = (odd_mode > fpc_pkg::MODE_BI_QUAD);
	// a seized even pin ignores its own mode entirely
	wire even_uni = !seize && !even_bad && (even_mode == fpc_pkg::MODE_UNI);
	wire even_stat = !seize && (even_mode == fpc_pkg::MODE_STATUS);
	wire odd_uni = (odd_mode == fpc_pkg::MODE_UNI);
	wire odd_stat = (odd_mode == fpc_pkg::MODE_STATUS);

	// per-sample count events
	wire [1:0] q_prev = eif.prev;
	wire [1:0] q_cur = eif.lvl;
	wire q_step = eif.tick && (q_prev != q_cur);
	// forward 00,01,11,10: pin0 (odd) is the high bit of the pair code
	wire [1:0] code_prev = {q_prev[0], q_prev[1]};
	wire [1:0] code_cur = {q_cur[0], q_cur[1]};
	function automatic logic [1:0] gray_nxt(input logic [1:0] c);
		case (c)
			2'b00: gray_nxt = 2'b01;
			2'b01: gray_nxt = 2'b11;
			2'b11: gray_nxt = 2'b10;
			default: gray_nxt = 2'b00;
		endcase
	endfunction
	wire q_fwd = q_step && (code_cur == gray_nxt(code_prev));
	wire q_rev = q_step && (code_prev == gray_nxt(code_cur));

	wire odd_rise = eif.tick && eif.rise[0];
	wire even_rise = eif.tick && eif.rise[1];
	wire inc_fwd = (odd_uni && odd_rise)
		|| (odd_mode == fpc_pkg::MODE_BI_PD && odd_rise && !eif.lvl[1])
		|| (odd_mode == fpc_pkg::MODE_BI_FR && odd_rise)
		|| (odd_mode == fpc_pkg::MODE_BI_QUAD && q_fwd);
	wire inc_rev = (odd_mode == fpc_pkg::MODE_BI_PD && odd_rise && eif.lvl[1])
		|| (odd_mode == fpc_pkg::MODE_BI_FR && even_rise)
		|| (odd_mode == fpc_pkg::MODE_BI_QUAD && q_rev);
	wire inc_even = even_uni && even_rise;

	wire capt = (state_ff == fpc_pkg::FPC_ST_RUN) && log_tick;
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			fpc_pkg::FPC_ST_IDLE: nxt_state = fpc_pkg::FPC_ST_RUN;
			fpc_pkg::FPC_ST_RUN: if (log_tick) begin
				nxt_state = fpc_pkg::FPC_ST_CAPT;
			end
			fpc_pkg::FPC_ST_CAPT: nxt_state = fpc_pkg::FPC_ST_RUN;
			default: nxt_state = fpc_pkg::FPC_ST_IDLE;
		endcase
	end

	// counts arriving on the boundary cycle go into the next period, never lost
	wire [CNT_W-1:0] nxt_fwd = (capt ? '0 : fwd_ff) + CNT_W'(inc_fwd);
	wire [CNT_W-1:0] nxt_rev = (capt ? '0 : rev_ff) + CNT_W'(inc_rev);
	wire [CNT_W-1:0] nxt_evu = (capt ? '0 : even_uni_ff) + CNT_W'(inc_even);
	wire quad_net = (odd_mode == fpc_pkg::MODE_BI_QUAD) || (odd_mode == fpc_pkg::MODE_BI_FR);
	wire indep = store_indep && (odd_mode == fpc_pkg::MODE_BI_PD);
	wire [CNT_W-1:0] net_val = fwd_ff - rev_ff;
	wire [CNT_W-1:0] odd_val = (odd_bi && !indep) || (odd_bi && quad_net) ? net_val : fwd_ff;
	wire [CNT_W-1:0] even_val = indep ? rev_ff : (even_uni ? even_uni_ff : '0);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= fpc_pkg::FPC_ST_IDLE;
			fwd_ff <= fpc_pkg::CNT_RST;
			rev_ff <= fpc_pkg::CNT_RST;
			even_uni_ff <= fpc_pkg::CNT_RST;
		end else begin
			state_ff <= nxt_state;
			fwd_ff <= nxt_fwd;
			rev_ff <= nxt_rev;
			even_uni_ff <= nxt_evu;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			odd_data_ff <= fpc_pkg::CNT_RST;
			even_data_ff <= fpc_pkg::CNT_RST;
			data_valid_ff <= 1'b0;
		end else begin
			data_valid_ff <= capt;
			if (capt) begin
				odd_data_ff <= odd_val;
				even_data_ff <= even_val;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			even_seized_ff <= 1'b0;
			cfg_err_ff <= 1'b0;
			status_lvl_ff <= 2'h0;
		end else begin
			even_seized_ff <= seize;
			cfg_err_ff <= odd_bad || (!seize && even_bad);
			status_lvl_ff <= {even_stat & eif.lvl[1], odd_stat & eif.lvl[0]};
		end
	end

	sequence s_boundary;
		state_ff == fpc_pkg::FPC_ST_RUN && log_tick;
	endsequence
	a_capt_valid: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_boundary |=> data_valid_ff ##1 !data_valid_ff)
		else $error("capture strobe not one cycle");
	a_uni_count: assert property (@(posedge sys_clk) disable iff (!rstn)
		odd_uni && odd_rise && !capt |=> fwd_ff == $past(fwd_ff) + CNT_W'(1))
		else $error("uni edge not counted");
	a_seize_even: assert property (@(posedge sys_clk) disable iff (!rstn)
		odd_bi ##1 odd_bi |-> even_seized_ff)
		else $error("even pin not seized");
	// a seized even pin must never leak its own uni count into the even datapoint
	a_seized_no_uni: assert property (@(posedge sys_clk) disable iff (!rstn)
		seize && !indep && capt |=> even_data_ff == '0)
		else $error("seized pin counted twice");
	a_pd_dir: assert property (@(posedge sys_clk) disable iff (!rstn)
		odd_mode == fpc_pkg::MODE_BI_PD && odd_rise |-> (inc_rev == eif.lvl[1]) && (inc_fwd != inc_rev))
		else $error("direction level ignored");
	a_fr_rev: assert property (@(posedge sys_clk) disable iff (!rstn)
		odd_mode == fpc_pkg::MODE_BI_FR && even_rise && !capt |=> rev_ff == $past(rev_ff) + CNT_W'(1))
		else $error("reverse pulse lost");
	a_quad_fwd: assert property (@(posedge sys_clk) disable iff (!rstn)
		odd_mode == fpc_pkg::MODE_BI_QUAD && eif.tick && q_prev == 2'b00 && q_cur == 2'b10 |-> inc_fwd && !inc_rev)
		else $error("quadrature forward step missed");
	a_even_mode: assert property (@(posedge sys_clk) disable iff (!rstn)
		!seize && even_mode == fpc_pkg::MODE_BI_PD |=> cfg_err_ff)
		else $error("bi mode on even not flagged");
	a_net_store: assert property (@(posedge sys_clk) disable iff (!rstn)
		capt && odd_mode == fpc_pkg::MODE_BI_QUAD |=> odd_data_ff == $past(fwd_ff) - $past(rev_ff))
		else $error("net value wrong");
endmodule // fpc_top

/* File: verif/fpc_meter_model.sv */
// fpc_meter_model: flow meter with two contact-closure outputs
// assumes the bench calls its tasks one at a time; 1 = closed
`timescale 1ns/1ps
module fpc_meter_model #(
	parameter int HOLD = 6
) (
	input wire logic sys_clk,
	output logic [1:0] pin_out
);
	initial pin_out = 2'b00;
	// each level held at least HOLD+1 clocks, longer than any sample period used
	task automatic level(input int idx, input logic v);
		@(posedge sys_clk);
		pin_out[idx] <= v;
		repeat (HOLD) @(posedge sys_clk);
	endtask
	task automatic pulses(input int idx, input int n);
		repeat (n) begin
			level(idx, 1'b1);
			level(idx, 1'b0);
		end
	endtask
	// code is {odd, even}; forward 00,01,11,10
	task automatic quad(input bit fwd, input int n);
		logic [1:0] code;
		repeat (n) begin
			code = {pin_out[0], pin_out[1]};
			code = fwd ? {code[0], ~code[1]} : {~code[0], code[1]};
			@(posedge sys_clk);
			pin_out <= {code[0], code[1]};
			repeat (HOLD) @(posedge sys_clk);
		end
	endtask
endmodule // fpc_meter_model

/* File: verif/tb.sv */
// tb: self-checking bench for the flow pulse input counter
// assumes sample periods of 2 or 3 clocks so pulses stay short
`timescale 1ns/1ps
module tb;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [1:0] pulse_pin;
	logic [2:0] odd_mode = fpc_pkg::MODE_UNI;
	logic [2:0] even_mode = fpc_pkg::MODE_UNI;
	logic store_indep = 1'b0;
	logic [17:0] sample_period = 18'h0_0002;
	logic log_tick = 1'b0;
	logic [31:0] odd_data_ff;
	logic [31:0] even_data_ff;
	logic data_valid_ff;
	logic even_seized_ff;
	logic cfg_err_ff;
	logic [1:0] status_lvl_ff;
	int miscompares = 0;
	int checked = 0;
	always #2 sys_clk = ~sys_clk;
	fpc_meter_model fpc_meter_model_inst (.sys_clk(sys_clk), .pin_out(pulse_pin));
	// small default so the zero-period fallback fits in the run
	fpc_top #(
		.SPER_DEF(3)
	) fpc_top_inst (.sys_clk(sys_clk), .rstn(rstn), .pulse_pin(pulse_pin), .odd_mode(odd_mode),
		.even_mode(even_mode), .store_indep(store_indep), .sample_period(sample_period), .log_tick(log_tick),
		.odd_data_ff(odd_data_ff), .even_data_ff(even_data_ff), .data_valid_ff(data_valid_ff),
		.even_seized_ff(even_seized_ff), .cfg_err_ff(cfg_err_ff), .status_lvl_ff(status_lvl_ff));
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// settle pipeline, then one log boundary; cmp=0 just flushes
	task automatic capture(input logic [31:0] eo, input logic [31:0] ee, input bit cmp);
		int i;
		repeat (12) @(posedge sys_clk);
		log_tick <= 1'b1;
		@(posedge sys_clk);
		log_tick <= 1'b0;
		#1;
		for (i = 0; i < 4 && data_valid_ff !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		if (cmp) begin
			chk({31'h0, data_valid_ff}, 32'h0000_0001);
			chk(odd_data_ff, eo);
			chk(even_data_ff, ee);
			@(posedge sys_clk);
			#1;
			chk({31'h0, data_valid_ff}, 32'h0000_0000);
		end
	endtask
	// config only changes between periods, so flush the partial one
	task automatic set_cfg(input logic [2:0] om, input logic [2:0] em, input logic ind, input logic [17:0] sp);
		@(posedge sys_clk);
		odd_mode <= om;
		even_mode <= em;
		store_indep <= ind;
		sample_period <= sp;
		capture(32'h0, 32'h0, 1'b0);
	endtask
	// four forward units, then one with the even pin high
	task automatic pd_run();
		fpc_meter_model_inst.pulses(0, 4);
		fpc_meter_model_inst.level(1, 1'b1);
		fpc_meter_model_inst.pulses(0, 1);
		fpc_meter_model_inst.level(1, 1'b0);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		capture(32'h0, 32'h0, 1'b0);
		fpc_meter_model_inst.pulses(0, 3);
		fpc_meter_model_inst.pulses(1, 2);
		chk({31'h0, even_seized_ff}, 32'h0000_0000);
		capture(32'h0000_0003, 32'h0000_0002, 1'b1);
		capture(32'h0000_0000, 32'h0000_0000, 1'b1);
		set_cfg(fpc_pkg::MODE_BI_PD, fpc_pkg::MODE_UNI, 1'b0, 18'h0_0002);
		chk({31'h0, even_seized_ff}, 32'h0000_0001);
		pd_run();
		capture(32'h0000_0003, 32'h0000_0000, 1'b1);
		set_cfg(fpc_pkg::MODE_BI_PD, fpc_pkg::MODE_UNI, 1'b1, 18'h0_0002);
		pd_run();
		capture(32'h0000_0004, 32'h0000_0001, 1'b1);
		set_cfg(fpc_pkg::MODE_BI_FR, fpc_pkg::MODE_OFF, 1'b0, 18'h0_0002);
		fpc_meter_model_inst.pulses(0, 2);
		fpc_meter_model_inst.pulses(1, 5);
		capture(32'hFFFF_FFFD, 32'h0000_0000, 1'b1);
		set_cfg(fpc_pkg::MODE_BI_QUAD, fpc_pkg::MODE_OFF, 1'b0, 18'h0_0003);
		fpc_meter_model_inst.quad(1'b1, 5);
		fpc_meter_model_inst.quad(1'b0, 1);
		capture(32'h0000_0004, 32'h0000_0000, 1'b1);
		set_cfg(fpc_pkg::MODE_OFF, fpc_pkg::MODE_BI_PD, 1'b0, 18'h0_0002);
		chk({31'h0, cfg_err_ff}, 32'h0000_0001);
		set_cfg(3'h6, fpc_pkg::MODE_OFF, 1'b0, 18'h0_0002);
		chk({31'h0, cfg_err_ff}, 32'h0000_0001);
		set_cfg(fpc_pkg::MODE_OFF, fpc_pkg::MODE_UNI, 1'b0, 18'h0_0002);
		chk({31'h0, cfg_err_ff}, 32'h0000_0000);
		set_cfg(fpc_pkg::MODE_STATUS, fpc_pkg::MODE_UNI, 1'b0, 18'h0_0002);
		fpc_meter_model_inst.level(0, 1'b1);
		repeat (6) @(posedge sys_clk);
		chk({30'h0, status_lvl_ff}, 32'h0000_0001);
		fpc_meter_model_inst.pulses(1, 2);
		fpc_meter_model_inst.level(0, 1'b0);
		capture(32'h0000_0000, 32'h0000_0002, 1'b1);
		// zero period falls back to the default; even pin as status input
		set_cfg(fpc_pkg::MODE_UNI, fpc_pkg::MODE_STATUS, 1'b0, 18'h0_0000);
		fpc_meter_model_inst.level(1, 1'b1);
		repeat (6) @(posedge sys_clk);
		chk({30'h0, status_lvl_ff}, 32'h0000_0002);
		fpc_meter_model_inst.pulses(0, 2);
		fpc_meter_model_inst.level(1, 1'b0);
		capture(32'h0000_0002, 32'h0000_0000, 1'b1);
		report_and_stop();
	end
	// whole sequence needs about 750 clocks
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		report_and_stop();
	end
endmodule // tb
